// File: dcr_map.svh
// Register offsets, field positions and reset values for the clock/reset block.
// Included by the package user files; definitions only.
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

`define DCR_OFS_CTRL        5'h00
`define DCR_OFS_STATUS      5'h04
`define DCR_OFS_CONFIG      5'h08

`define DCR_CTRL_SOFT_RST   0
`define DCR_CTRL_CAL_START  1
`define DCR_CTRL_RESET      32'h0000_0000

`define DCR_ST_RESET_REQ    0
`define DCR_ST_PHY_RUN      1
`define DCR_ST_CTL_RUN      2
`define DCR_ST_CAL_BUSY     3
`define DCR_ST_CAL_PASS     4
`define DCR_ST_CAL_FAIL     5

`define DCR_CFG_RATIO_LSB   0
`define DCR_CFG_PLL_LSB     4
`define DCR_CFG_DLL_LSB     6
`define DCR_CFG_OCT_MASTER  8

`define DCR_RESP_OKAY       2'h0
`define DCR_RESP_SLVERR     2'h2

`endif

// File: dcr_pkg.sv
// Types shared by the clock/reset block and its calibration timer.
// Constants live in dcr_map.svh.
package dcr_pkg;

  typedef enum logic [1:0] {
    dcr_share_none,
    dcr_share_master,
    dcr_share_slave
  } dcr_share_t;

  typedef enum logic [1:0] {
    dcr_cal_idle,
    dcr_cal_run,
    dcr_cal_pass,
    dcr_cal_fail
  } dcr_cal_state_t;

  typedef struct packed {
    logic cal_fail;
    logic cal_pass;
    logic cal_busy;
    logic ctl_run;
    logic phy_run;
    logic reset_req;
  } dcr_status_t;

endpackage

// File: dcr_cal_timer.sv
// Read-valid timeout during calibration.
// Assumes start and read_valid come from logic on clk.
`timescale 1ns/1ps
module dcr_cal_timer #(
  parameter int TIMEOUT_WIDTH = 8
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic phy_run,
  input  wire logic start,
  input  wire logic read_valid,
  output dcr_pkg::dcr_cal_state_t state
);

  logic [TIMEOUT_WIDTH-1:0] count;
  dcr_pkg::dcr_cal_state_t  next_state;
  wire                      expired = &count;

  always_comb begin
    next_state = state;
    unique case (state)
      dcr_pkg::dcr_cal_idle,
      dcr_pkg::dcr_cal_pass,
      dcr_pkg::dcr_cal_fail: if (start) next_state = dcr_pkg::dcr_cal_run;
      dcr_pkg::dcr_cal_run: begin
        if (read_valid)
          next_state = dcr_pkg::dcr_cal_pass;
        else if (expired)
          next_state = dcr_pkg::dcr_cal_fail;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn || !phy_run) begin
      state <= dcr_pkg::dcr_cal_idle;
      count <= '0;
    end else begin
      state <= next_state;
      count <= (next_state == dcr_pkg::dcr_cal_run && state == dcr_pkg::dcr_cal_run) ? count + 1'b1 : '0;
    end
  end

endmodule

// File: dcr_clock_reset.sv
// Clock, reset and resource-sharing logic of the DDR physical layer.
// Assumes one clock; pins are synchronised here; registers over AXI4-Lite.
// How it works
// - Global reset low resets the PLL and all logic in the block.
// - Soft reset low holds the PHY in reset; PLL keeps running.
// - Soft reset low also holds the controller reset output low.
// - Reset request output follows PLL lock: high locked, low unlocked.
// - In master mode, lock, reset and DLL codeword are exported.
// - With no sharing, shared outputs stay zero and shared inputs unused.
// - Ratio parameter is 1 full-rate or 2 half-rate; widths scale.
// - Read-valid timeout during calibration reports calibration failure.
// - Controller words go to memory lower slot first, higher after.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dcr_map.svh"
module dcr_clock_reset #(
  parameter int                  RATE_RATIO_PARAM          = 2,
  parameter int                  MEM_DQ_WIDTH              = 8,
  parameter int                  DLL_DELAY_CTRL_WIDTH      = 6,
  parameter int                  OCT_SERIES_WIDTH          = 14,
  parameter int                  OCT_PARALLEL_WIDTH        = 14,
  parameter int                  READ_VALID_TIMEOUT_WIDTH  = 8,
  parameter dcr_pkg::dcr_share_t PLL_SHARING               = dcr_pkg::dcr_share_none,
  parameter dcr_pkg::dcr_share_t DLL_SHARING               = dcr_pkg::dcr_share_none,
  parameter bit                  TERMINATION_MASTER_OPTION = 1'b1
) (
  input  wire logic                                     clk,
  input  wire logic                                     rstn,
  input  wire logic                                     soft_reset_n,
  input  wire logic                                     pll_locked,
  output logic                                          pll_reset,
  output logic                                          reset_request_n,
  output logic                                          phy_reset_n,
  output logic                                          ctl_reset_n,
  input  wire logic                                     shared_ctl_reset_n_in,
  output logic                                          shared_ctl_reset_n_out,
  output logic                                          shared_pll_locked_out,
  input  wire logic [DLL_DELAY_CTRL_WIDTH-1:0]          dll_code_local,
  input  wire logic [DLL_DELAY_CTRL_WIDTH-1:0]          shared_dll_code_in,
  output logic      [DLL_DELAY_CTRL_WIDTH-1:0]          shared_dll_code_out,
  output logic      [DLL_DELAY_CTRL_WIDTH-1:0]          phy_dll_code,
  input  wire logic [OCT_SERIES_WIDTH-1:0]              oct_series_local,
  input  wire logic [OCT_PARALLEL_WIDTH-1:0]            oct_parallel_local,
  input  wire logic [OCT_SERIES_WIDTH-1:0]              oct_series_in,
  input  wire logic [OCT_PARALLEL_WIDTH-1:0]            oct_parallel_in,
  output logic      [OCT_SERIES_WIDTH-1:0]              phy_oct_series,
  output logic      [OCT_PARALLEL_WIDTH-1:0]            phy_oct_parallel,
  input  wire logic [RATE_RATIO_PARAM*MEM_DQ_WIDTH-1:0] ctl_wdata,
  input  wire logic                                     ctl_wvalid,
  output logic                                          ctl_wready,
  output logic      [RATE_RATIO_PARAM*MEM_DQ_WIDTH-1:0] ctl_rdata,
  output logic                                          ctl_rdata_valid,
  output logic      [MEM_DQ_WIDTH-1:0]                  mem_dq_out,
  output logic                                          mem_dq_oe,
  input  wire logic [MEM_DQ_WIDTH-1:0]                  mem_dq_in,
  input  wire logic                                     mem_rd_beat,
  input  wire logic [4:0]                               s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  output logic      [1:0]                               s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  input  wire logic [4:0]                               s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic      [31:0]                              s_axi_rdata,
  output logic      [1:0]                               s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready
);

  localparam int W = MEM_DQ_WIDTH;
  localparam int R = RATE_RATIO_PARAM;

  function automatic logic [W-1:0] slot_get(input logic [R*W-1:0] word, input logic [1:0] idx);
    slot_get = word[idx*W +: W];
  endfunction

  function automatic logic [R*W-1:0] slot_put(input logic [R*W-1:0] word, input logic [1:0] idx,
                                               input logic [W-1:0] beat);
    logic [R*W-1:0] tmp;
    tmp = word;
    tmp[idx*W +: W] = beat;
    slot_put = tmp;
  endfunction

  // Pin synchronisers
  logic [1:0]   soft_sync;
  logic [1:0]   lock_sync;
  logic [1:0]   shr_sync;
  logic [W:0]   rd_sync1;
  logic [W:0]   rd_sync2;
  logic         sw_soft;
  logic         ctl_hold1;
  logic         ctl_hold2;

  wire soft_ok   = soft_sync[1] && !sw_soft;
  wire lock_ok   = lock_sync[1];
  wire phy_run   = soft_ok;
  wire is_pll_sl = PLL_SHARING == dcr_pkg::dcr_share_slave;
  wire ctl_src   = is_pll_sl ? shr_sync[1] : ctl_hold2;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_sync <= 2'h0;
      lock_sync <= 2'h0;
      shr_sync  <= 2'h0;
      rd_sync1  <= '0;
      rd_sync2  <= '0;
      ctl_hold1 <= 1'b0;
      ctl_hold2 <= 1'b0;
    end else begin
      soft_sync <= {soft_sync[0], soft_reset_n};
      lock_sync <= {lock_sync[0], pll_locked};
      shr_sync  <= {shr_sync[0], shared_ctl_reset_n_in};
      rd_sync1  <= {mem_rd_beat, mem_dq_in};
      rd_sync2  <= rd_sync1;
      ctl_hold1 <= lock_ok && soft_ok;
      ctl_hold2 <= ctl_hold1 && lock_ok && soft_ok;
    end
  end

  assign pll_reset       = !rstn;
  assign reset_request_n = lock_ok;
  assign phy_reset_n     = phy_run;
  assign ctl_reset_n     = ctl_src && soft_ok;

  // Sharing exports, zero unless master
  assign shared_ctl_reset_n_out = (PLL_SHARING == dcr_pkg::dcr_share_master) ? ctl_hold2 : 1'b0;
  assign shared_pll_locked_out  = (PLL_SHARING == dcr_pkg::dcr_share_master) ? lock_ok : 1'b0;
  assign shared_dll_code_out    = (DLL_SHARING == dcr_pkg::dcr_share_master) ? dll_code_local : '0;
  assign phy_dll_code           = (DLL_SHARING == dcr_pkg::dcr_share_slave) ? shared_dll_code_in
                                                                             : dll_code_local;
  assign phy_oct_series   = TERMINATION_MASTER_OPTION ? oct_series_local : oct_series_in;
  assign phy_oct_parallel = TERMINATION_MASTER_OPTION ? oct_parallel_local : oct_parallel_in;

  // Write slots, lower half first
  logic [R*W-1:0] wbuf;
  logic [1:0]     wslot;
  logic           wbusy;
  wire            wtake = ctl_wvalid && ctl_wready;
  assign ctl_wready = !wbusy && phy_run;

  always_ff @(posedge clk) begin
    if (!rstn || !phy_run) begin
      wbuf       <= '0;
      wslot      <= 2'h0;
      wbusy      <= 1'b0;
      mem_dq_out <= '0;
      mem_dq_oe  <= 1'b0;
    end else if (wtake) begin
      wbuf       <= ctl_wdata;
      mem_dq_out <= slot_get(ctl_wdata, 2'h0);
      mem_dq_oe  <= 1'b1;
      wslot      <= 2'h1;
      wbusy      <= R > 1;
    end else if (wbusy) begin
      mem_dq_out <= slot_get(wbuf, wslot);
      wslot      <= wslot + 2'h1;
      wbusy      <= wslot != 2'(R - 1);
    end else begin
      mem_dq_oe  <= 1'b0;
    end
  end

  // Read slots, first beat lands in lower half
  logic [R*W-1:0] rbuf;
  logic [1:0]     rslot;
  wire            rbeat = rd_sync2[W];
  wire            rlast = rslot == 2'(R - 1);

  always_ff @(posedge clk) begin
    if (!rstn || !phy_run) begin
      rbuf            <= '0;
      rslot           <= 2'h0;
      ctl_rdata       <= '0;
      ctl_rdata_valid <= 1'b0;
    end else begin
      ctl_rdata_valid <= rbeat && rlast;
      if (rbeat) begin
        rbuf  <= slot_put(rbuf, rslot, rd_sync2[W-1:0]);
        rslot <= rlast ? 2'h0 : rslot + 2'h1;
        if (rlast)
          ctl_rdata <= slot_put(rbuf, rslot, rd_sync2[W-1:0]);
      end
    end
  end

  // Calibration timeout
  dcr_pkg::dcr_cal_state_t cal_state;
  logic                    cal_start;

  dcr_cal_timer #(
    .TIMEOUT_WIDTH (READ_VALID_TIMEOUT_WIDTH)
  ) u_cal_timer (
    .clk        (clk),
    .rstn       (rstn),
    .phy_run    (phy_run),
    .start      (cal_start),
    .read_valid (ctl_rdata_valid),
    .state      (cal_state)
  );

  dcr_pkg::dcr_status_t status;
  assign status = '{cal_fail:  cal_state == dcr_pkg::dcr_cal_fail,
                    cal_pass:  cal_state == dcr_pkg::dcr_cal_pass,
                    cal_busy:  cal_state == dcr_pkg::dcr_cal_run,
                    ctl_run:   ctl_reset_n,
                    phy_run:   phy_run,
                    reset_req: reset_request_n};

  // AXI4-Lite slave
  logic        aw_have;
  logic        w_have;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         do_write = aw_have && w_have && !s_axi_bvalid;
  wire         wr_ctrl  = aw_addr == `DCR_OFS_CTRL;
  wire         rd_ctrl  = s_axi_araddr == `DCR_OFS_CTRL;
  wire         rd_stat  = s_axi_araddr == `DCR_OFS_STATUS;
  wire         rd_cfg   = s_axi_araddr == `DCR_OFS_CONFIG;
  wire [31:0]  cfg_word = 32'(R) << `DCR_CFG_RATIO_LSB | 32'(PLL_SHARING) << `DCR_CFG_PLL_LSB
                        | 32'(DLL_SHARING) << `DCR_CFG_DLL_LSB | 32'(TERMINATION_MASTER_OPTION) << `DCR_CFG_OCT_MASTER;
  wire [31:0]  rd_word  = rd_ctrl ? 32'(sw_soft) << `DCR_CTRL_SOFT_RST :
                          rd_stat ? 32'(status) : rd_cfg ? cfg_word : 32'h0000_0000;

  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_addr      <= 5'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCR_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `DCR_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      sw_soft      <= 1'(`DCR_CTRL_RESET >> `DCR_CTRL_SOFT_RST);
      cal_start    <= 1'b0;
    end else begin
      cal_start <= 1'b0;
      if (s_axi_awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ctrl || aw_addr == `DCR_OFS_STATUS || aw_addr == `DCR_OFS_CONFIG)
                        ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
        if (wr_ctrl && w_strb[0]) begin
          sw_soft   <= w_data[`DCR_CTRL_SOFT_RST];
          cal_start <= w_data[`DCR_CTRL_CAL_START];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_ctrl || rd_stat || rd_cfg) ? `DCR_RESP_OKAY : `DCR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: dcr_clock_reset_chk.sv
// Assertion checker for the clock/reset block, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module dcr_clock_reset_chk #(
  parameter int                  RATE_RATIO_PARAM          = 2,
  parameter int                  MEM_DQ_WIDTH              = 8,
  parameter int                  OCT_SERIES_WIDTH          = 14,
  parameter int                  OCT_PARALLEL_WIDTH        = 14,
  parameter dcr_pkg::dcr_share_t PLL_SHARING               = dcr_pkg::dcr_share_none,
  parameter bit                  TERMINATION_MASTER_OPTION = 1'b1
) (
  input wire logic                                     clk,
  input wire logic                                     rstn,
  input wire logic                                     soft_reset_n,
  input wire logic                                     pll_locked,
  input wire logic                                     pll_reset,
  input wire logic                                     reset_request_n,
  input wire logic                                     phy_reset_n,
  input wire logic                                     ctl_reset_n,
  input wire logic                                     shared_ctl_reset_n_out,
  input wire logic                                     shared_pll_locked_out,
  input wire logic [OCT_SERIES_WIDTH-1:0]              oct_series_in,
  input wire logic [OCT_PARALLEL_WIDTH-1:0]            oct_parallel_in,
  input wire logic [OCT_SERIES_WIDTH-1:0]              phy_oct_series,
  input wire logic [OCT_PARALLEL_WIDTH-1:0]            phy_oct_parallel,
  input wire logic [RATE_RATIO_PARAM*MEM_DQ_WIDTH-1:0] ctl_wdata,
  input wire logic                                     ctl_wvalid,
  input wire logic                                     ctl_wready,
  input wire logic [MEM_DQ_WIDTH-1:0]                  mem_dq_out,
  input wire logic                                     mem_dq_oe
);
  localparam int W = MEM_DQ_WIDTH;
  logic [RATE_RATIO_PARAM*W-1:0] wd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Last word taken from the controller
  always_ff @(posedge clk) if (ctl_wvalid && ctl_wready) wd <= ctl_wdata;

  property p_glob; disable iff (1'b0) !rstn |-> pll_reset; endproperty
  property p_soft_pll; !soft_reset_n && rstn |-> !pll_reset; endproperty
  property p_soft; !soft_reset_n [*4] |-> !phy_reset_n && !ctl_reset_n; endproperty
  property p_lock_hi; pll_locked [*4] |-> reset_request_n; endproperty
  property p_lock_lo; !pll_locked [*4] |-> !reset_request_n; endproperty
  property p_ctl_rel; $rose(ctl_reset_n) |-> reset_request_n && $past(soft_reset_n, 2) && $past(rstn, 3); endproperty
  property p_noshare;
    PLL_SHARING == dcr_pkg::dcr_share_none |-> !shared_pll_locked_out && !shared_ctl_reset_n_out;
  endproperty
  property p_oct;
    !TERMINATION_MASTER_OPTION |-> phy_oct_series == oct_series_in && phy_oct_parallel == oct_parallel_in;
  endproperty
  property p_slots;
    RATE_RATIO_PARAM == 2 && ctl_wvalid && ctl_wready |=> mem_dq_oe && mem_dq_out == wd[W-1:0]
      ##1 mem_dq_oe && mem_dq_out == wd[2*W-1:W];
  endproperty
  property p_ratio; RATE_RATIO_PARAM == 2 && ctl_wvalid && ctl_wready |=> !ctl_wready; endproperty

  a_glob: assert property (p_glob) else $error("pll not reset in global reset");
  a_soft_pll: assert property (p_soft_pll) else $error("pll reset by soft reset");
  a_soft: assert property (p_soft) else $error("soft reset not held");
  a_lock_hi: assert property (p_lock_hi) else $error("reset request low while locked");
  a_lock_lo: assert property (p_lock_lo) else $error("reset request high while unlocked");
  a_ctl_rel: assert property (p_ctl_rel) else $error("controller reset released early");
  a_noshare: assert property (p_noshare) else $error("shared outputs driven");
  a_oct: assert property (p_oct) else $error("termination buses not from outside");
  a_slots: assert property (p_slots) else $error("slot order wrong");
  a_ratio: assert property (p_ratio) else $error("second slot not held off");

  c_soft: cover property (!soft_reset_n [*4]);
  c_take: cover property (ctl_wvalid && ctl_wready ##2 ctl_wvalid && ctl_wready);
  c_loss: cover property ($fell(reset_request_n));
endmodule

bind dcr_clock_reset dcr_clock_reset_chk #(
  .RATE_RATIO_PARAM(RATE_RATIO_PARAM),
  .MEM_DQ_WIDTH(MEM_DQ_WIDTH),
  .OCT_SERIES_WIDTH(OCT_SERIES_WIDTH),
  .OCT_PARALLEL_WIDTH(OCT_PARALLEL_WIDTH),
  .PLL_SHARING(PLL_SHARING),
  .TERMINATION_MASTER_OPTION(TERMINATION_MASTER_OPTION)
) u_chk (.*);

// File: dcr_pll_model.sv
// Behavioural PLL in front of the clock/reset block.
// Assumes pll_reset from the block and a lock-drop request from the bench.
`timescale 1ns/1ps
module dcr_pll_model #(
  parameter int LOCK_CYCLES = 6
) (
  input  wire logic clk,
  input  wire logic pll_reset,
  input  wire logic drop,
  output logic      pll_locked
);
  int cnt;

  initial begin
    cnt = 0;
    pll_locked = 1'b0;
  end

  // Soft reset never reaches here, so clocks keep running
  always @(posedge clk) begin
    if (pll_reset || drop) begin
      cnt        <= 0;
      pll_locked <= 1'b0;
    end else if (cnt < LOCK_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      pll_locked <= 1'b1;
    end
  end
endmodule

// File: test_dcr_clock_reset.sv
// Self-checking bench for the clock/reset block with a PLL model.
// Assumes the package, register map header and checker are compiled first.
`timescale 1ns/1ps
`include "dcr_map.svh"
module test_dcr_clock_reset;
  typedef struct { string nm; logic [33:0] v; } dcr_note_t;
  logic        clk, rstn, soft_reset_n, drop, pll_locked, pll_reset, reset_request_n, phy_reset_n, ctl_reset_n;
  logic        shared_ctl_reset_n_in, shared_ctl_reset_n_out, shared_pll_locked_out, ctl_wvalid, ctl_wready;
  logic        ctl_rdata_valid, mem_dq_oe, mem_rd_beat, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [5:0]  dll_code_local, shared_dll_code_in, shared_dll_code_out, phy_dll_code;
  logic [13:0] oct_series_local, oct_parallel_local, oct_series_in, oct_parallel_in, phy_oct_series, phy_oct_parallel;
  logic [7:0]  mem_dq_out, mem_dq_in;
  logic [15:0] ctl_wdata, ctl_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  dcr_note_t   q[$];
  int          fail_count, checks_done;

  dcr_clock_reset #(.READ_VALID_TIMEOUT_WIDTH(4), .TERMINATION_MASTER_OPTION(1'b0)) u_dut (.*);
  dcr_pll_model u_pll (.clk(clk), .pll_reset(pll_reset), .drop(drop), .pll_locked(pll_locked));

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic note(input string nm, input logic [33:0] v);
    q.push_back('{nm, v});
  endtask

  task automatic take(input logic [33:0] g);
    dcr_note_t n;
    n = '{"unexpected result", 'x};
    if (q.size() > 0) n = q.pop_front();
    chk(n.nm, n.v, g);
  endtask

  // Results are matched against notes in order of appearance
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) take({32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) take({s_axi_rresp, s_axi_rdata});
    if (ctl_rdata_valid) take(34'(ctl_rdata));
    if (mem_dq_oe) take(34'(mem_dq_out));
  end

  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw, pb;
    note("bresp", 34'(r));
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pb) begin
      @(negedge clk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      if (s_axi_bvalid) pb = 1'b0;
      @(posedge clk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= pb;
    end
    @(posedge clk);
  endtask

  task automatic axr(input logic [4:0] a, input logic [33:0] e);
    logic pa, pb;
    note("rdata", e);
    pa = 1'b1;
    pb = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pb) begin
      @(negedge clk);
      if (s_axi_arready) pa = 1'b0;
      if (s_axi_rvalid) pb = 1'b0;
      @(posedge clk);
      s_axi_arvalid <= pa;
      s_axi_rready <= pb;
    end
    @(posedge clk);
  endtask

  task automatic wr_word(input logic [15:0] d);
    logic ok;
    note("slot0", 34'(d[7:0]));
    note("slot1", 34'(d[15:8]));
    ctl_wdata <= d;
    ctl_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ok = ctl_wready;
      @(posedge clk);
    end while (!ok);
  endtask

  task automatic rd_word(input logic [15:0] d);
    note("ctl_rdata", 34'(d));
    for (int i = 0; i < 2; i++) begin
      mem_rd_beat <= 1'b1;
      mem_dq_in <= d[i*8 +: 8];
      @(posedge clk);
    end
    mem_rd_beat <= 1'b0;
    mem_dq_in <= ~d[15:8];
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h7b9c));
    {clk, rstn, drop, ctl_wvalid, mem_rd_beat, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctl_wdata} = '0;
    soft_reset_n = 1'b1;
    s_axi_wstrb = 4'hf;
    {shared_ctl_reset_n_in, dll_code_local, shared_dll_code_in, mem_dq_in} = 21'($urandom);
    {oct_series_local, oct_parallel_local} = 28'($urandom);
    {oct_series_in, oct_parallel_in} = 28'($urandom);
    repeat (8) @(posedge clk);
    chk("pll_reset", 34'h1, pll_reset);
    rstn <= 1'b1;
    repeat (16) @(posedge clk);
    chk("resets after lock", 34'h7, {reset_request_n, phy_reset_n, ctl_reset_n});
    chk("shared outputs", 34'h0, {shared_pll_locked_out, shared_ctl_reset_n_out, shared_dll_code_out});
    chk("phy_dll_code", 34'(dll_code_local), 34'(phy_dll_code));
    chk("phy_oct", {oct_series_in, oct_parallel_in}, {phy_oct_series, phy_oct_parallel});
    $display("test reset and sharing done");
    axr(`DCR_OFS_CTRL, 34'h0);
    axr(`DCR_OFS_CONFIG, 34'h2);
    axr(5'h0c, {`DCR_RESP_SLVERR, 32'h0});
    axw(5'h10, 32'h1, `DCR_RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 4; i++) wr_word(16'($urandom));
    ctl_wvalid <= 1'b0;
    repeat (4) @(posedge clk);
    rd_word(16'($urandom));
    repeat (6) @(posedge clk);
    $display("test data path done");
    axw(`DCR_OFS_CTRL, 32'h2, `DCR_RESP_OKAY);
    repeat (30) @(posedge clk);
    axr(`DCR_OFS_STATUS, 34'h27);
    axw(`DCR_OFS_CTRL, 32'h2, `DCR_RESP_OKAY);
    rd_word(16'($urandom));
    repeat (6) @(posedge clk);
    axr(`DCR_OFS_STATUS, 34'h17);
    $display("test calibration done");
    soft_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("soft hold", 34'h4, {pll_reset, reset_request_n, phy_reset_n, ctl_reset_n});
    soft_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("soft release", 34'h7, {pll_reset, reset_request_n, phy_reset_n, ctl_reset_n});
    axw(`DCR_OFS_CTRL, 32'h1, `DCR_RESP_OKAY);
    axr(`DCR_OFS_CTRL, 34'h1);
    chk("ctrl soft", 34'h0, phy_reset_n);
    axw(`DCR_OFS_STATUS, 32'h0, `DCR_RESP_OKAY);
    $display("test soft reset done");
    drop <= 1'b1;
    repeat (6) @(posedge clk);
    chk("lock lost", 34'h0, reset_request_n);
    drop <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    chk("mid reset", 34'h8, {pll_reset, reset_request_n, phy_reset_n, ctl_reset_n});
    rstn <= 1'b1;
    repeat (16) @(posedge clk);
    chk("after reset", 34'h7, {pll_reset, reset_request_n, phy_reset_n, ctl_reset_n});
    axr(`DCR_OFS_CTRL, 34'h0);
    $display("test lock and global reset done");
    report_and_stop();
  end
endmodule
